// [rtl/dbm_pkg.sv]
/*
 * dbm_pkg: constants and carrier types for the bay manager.
 * Assumes a 100 MHz clock, five slots and two fans.
 */
package dbm_pkg;
    localparam int NSLOT = 5;
    localparam int NFAN = 2;
    localparam int CLK_KHZ = 100_000;
    localparam int SETTLE_MS = 50;
    localparam int RAMP_MS = 10;
    localparam int FLASH_MS = 2000;
    localparam int BLINK_MS = 125;
    localparam int FAN_WIN_MS = 1000;
    localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
    localparam int RAMP_CYC = RAMP_MS * CLK_KHZ;
    localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
    localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
    localparam int FAN_WIN_CYC = FAN_WIN_MS * CLK_KHZ;
    localparam logic [15:0] FAN_LOW_DEF = 16'h0014;
    // scsi id bases
    localparam logic [3:0] ID_BASE_PRI = 4'h0;
    localparam logic [3:0] ID_BASE_SEC = 4'h8;
    // program store: boot part, then rewritable part
    localparam int BOOT_BYTES = 8 * 1024;
    localparam int OPER_BYTES = 24 * 1024;
    localparam int PROG_BYTES = BOOT_BYTES + OPER_BYTES;
    localparam logic [14:0] BOOT_END = 15'h2000;
    // private two-wire bus
    localparam logic [15:0] I2C_QDIV = 16'h00FA;
    localparam logic [6:0] TEMP_ADDR = 7'h48;
    localparam logic [7:0] TEMP_PTR = 8'hAA;
    localparam logic [6:0] STORE_ADDR = 7'h48;
    localparam logic [5:0] SYM_RSTART = 6'h13;
    localparam logic [5:0] SYM_STOP = 6'h26;
    localparam logic [5:0] RX_FIRST = 6'h1B;
    localparam logic [5:0] RX_LAST = 6'h22;
    // enclosure services operations
    localparam logic [2:0] OP_FAULT_SET = 3'h0;
    localparam logic [2:0] OP_FAULT_CLR = 3'h1;
    localparam logic [2:0] OP_POWER_DOWN = 3'h2;
    localparam logic [2:0] OP_FAN_STAT = 3'h3;
    localparam logic [2:0] OP_READ_TEMP = 3'h4;
    localparam logic [2:0] OP_READ_STORE = 3'h5;

    typedef enum logic [3:0] {
        SLOT_OFF = 4'b0001,
        SLOT_SETTLE = 4'b0010,
        SLOT_RAMP = 4'b0100,
        SLOT_ON = 4'b1000
    } dbm_slot_t;

    typedef struct packed {
        logic valid;
        logic [2:0] op;
        logic [2:0] slot;
        logic [7:0] arg;
    } dbm_cmd_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] data;
    } dbm_rsp_t;
endpackage : dbm_pkg

// [rtl/dbm_bay_manager.sv]
/*
 * dbm_bay_manager: hot-swap drive bay manager.
 * Assumes scsi target and management bus front ends on clk.
 */
// Operation
// R1: no card, all slots powered always
// R2: failed drive reported: power removed
// R3: insertion settles, then ramped power on
// R4: withdrawal under system power: off now
// R5: strap high primary, low secondary numbering
// R6: three slots: ids 0-2 or 8-10
// R7: five slots primary: ids 0-4
// R8: slot lines carry id and spin-up
// R9: fault led follows both command paths
// R10: flash fault leds two seconds after self-test
// R11: activity led lit while drive accessed
// R12: two fan tach inputs measured
// R13: fan below threshold sends management message
// R14: no detection after first fan failure
// R15: scsi target carries enclosure services
// R16: 8K boot permanent, 24K rewritable
// R17: temp and 256-byte store via private bus
// R18: host sets fault, powers down, asks fans
// R19: settle delay and threshold are parameters
// R20: each slot powered independently
`timescale 1ns/10ps
`default_nettype none

module dbm_bay_manager #(
    parameter int SETTLE_CYCLES = dbm_pkg::SETTLE_CYC,
    parameter int RAMP_CYCLES = dbm_pkg::RAMP_CYC,
    parameter int FLASH_CYCLES = dbm_pkg::FLASH_CYC,
    parameter int BLINK_CYCLES = dbm_pkg::BLINK_CYC,
    parameter int FAN_WIN_CYCLES = dbm_pkg::FAN_WIN_CYC,
    parameter logic [15:0] FAN_LOW_THRESH = dbm_pkg::FAN_LOW_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // board straps and status pins
    input wire logic cardPresent,
    input wire logic primaryStrap,
    input wire logic threeSlotBoard,
    input wire logic sysPowerOn,
    input wire logic [dbm_pkg::NSLOT-1:0] drvPresent,
    input wire logic [dbm_pkg::NSLOT-1:0] drvActive,
    input wire logic [dbm_pkg::NFAN-1:0] fanTach,
    // self-test result
    input wire logic postPass,
    // enclosure services from the scsi target
    input wire dbm_pkg::dbm_cmd_t esCmd,
    output dbm_pkg::dbm_rsp_t esRsp,
    // system management bus side
    input wire logic mgmtFaultValid,
    input wire logic [2:0] mgmtFaultSlot,
    input wire logic mgmtFaultOn,
    output logic fanLowMsg,
    output logic fanLowIdx,
    // program store update and fetch
    input wire logic progWrEn,
    input wire logic [14:0] progAddr,
    input wire logic [7:0] progWrData,
    output logic [7:0] progRdData,
    output logic progWrRefused,
    // slot outputs
    output logic [dbm_pkg::NSLOT-1:0] slotPower,
    output logic [dbm_pkg::NSLOT-1:0] slotRamp,
    output logic [dbm_pkg::NSLOT-1:0] faultLed,
    output logic [dbm_pkg::NSLOT-1:0] activityLed,
    output logic [dbm_pkg::NSLOT-1:0] spinDelay,
    output logic [dbm_pkg::NSLOT*4-1:0] slotScsiId,
    // private two-wire bus, open drain
    input wire logic privSclIn,
    output logic privSclOut,
    output logic privSclOe,
    input wire logic privSdaIn,
    output logic privSdaOut,
    output logic privSdaOe
);
    localparam int NS = dbm_pkg::NSLOT;

    logic [1:0] rstPipe_q;
    logic rstn;
    logic [NS-1:0] presMeta_q, pres_q, actMeta_q, act_q;
    logic [dbm_pkg::NFAN-1:0] tachMeta_q, tach_q, tachOld_q;
    logic [3:0] strapMeta_q, strap_q;
    logic cardOk, sysOn, primary, three;
    logic sclMeta_q, scl_q, sdaMeta_q, sda_q;

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstn = rstPipe_q[1];

    // pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            presMeta_q <= '0;
            pres_q <= '0;
            actMeta_q <= '0;
            act_q <= '0;
            tachMeta_q <= '0;
            tach_q <= '0;
            tachOld_q <= '0;
            strapMeta_q <= 4'h0;
            strap_q <= 4'h0;
            sclMeta_q <= 1'b1;
            scl_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            presMeta_q <= drvPresent;
            pres_q <= presMeta_q;
            actMeta_q <= drvActive;
            act_q <= actMeta_q;
            tachMeta_q <= fanTach;
            tach_q <= tachMeta_q;
            tachOld_q <= tach_q;
            strapMeta_q <= {cardPresent, sysPowerOn, primaryStrap,
                threeSlotBoard};
            strap_q <= strapMeta_q;
            sclMeta_q <= privSclIn;
            scl_q <= sclMeta_q;
            sdaMeta_q <= privSdaIn;
            sda_q <= sdaMeta_q;
        end
    end
    assign cardOk = strap_q[3];
    assign sysOn = strap_q[2];
    assign primary = strap_q[1];
    assign three = strap_q[0];

    logic esValid, i2cBusy_q, i2cDone_q;
    assign esValid = esCmd.valid;

    // per slot power sequencing
    dbm_pkg::dbm_slot_t slotSt_q [NS];
    logic [31:0] slotCnt_q [NS];
    logic [NS-1:0] failed_q;
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_slot
            logic downReq, gone;
            assign downReq = esValid && esCmd.op == dbm_pkg::OP_POWER_DOWN
                && esCmd.slot == 3'(gi);
            assign gone = !pres_q[gi];
            // R2 failed latch, cleared on removal; set wins
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    failed_q[gi] <= 1'b0;
                end else if (downReq) begin
                    failed_q[gi] <= 1'b1;
                end else if (gone) begin
                    failed_q[gi] <= 1'b0;
                end
            end
            // R20 independent slot state
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    slotSt_q[gi] <= dbm_pkg::SLOT_OFF;
                    slotCnt_q[gi] <= '0;
                end else begin
                    slotCnt_q[gi] <= slotCnt_q[gi] + 32'd1;
                    case (slotSt_q[gi])
                        dbm_pkg::SLOT_OFF: begin
                            slotCnt_q[gi] <= '0;
                            if (!gone && !failed_q[gi] && !downReq) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_SETTLE;
                            end
                        end
                        // R3 seating delay before power
                        dbm_pkg::SLOT_SETTLE: begin
                            if (gone || downReq) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_OFF;
                            end else if (slotCnt_q[gi]
                                    == 32'(SETTLE_CYCLES - 1)) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_RAMP;
                                slotCnt_q[gi] <= '0;
                            end
                        end
                        // R3 controlled ramp phase
                        dbm_pkg::SLOT_RAMP: begin
                            if ((gone && sysOn) || downReq) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_OFF;
                            end else if (slotCnt_q[gi]
                                    == 32'(RAMP_CYCLES - 1)) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_ON;
                            end
                        end
                        // R4 R2 withdrawal or spin-down
                        dbm_pkg::SLOT_ON: begin
                            if ((gone && sysOn) || downReq) begin
                                slotSt_q[gi] <= dbm_pkg::SLOT_OFF;
                            end
                        end
                        default: slotSt_q[gi] <= dbm_pkg::SLOT_OFF;
                    endcase
                end
            end
            // R1 no card: power never switched
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    slotPower[gi] <= 1'b1;
                    slotRamp[gi] <= 1'b0;
                end else begin
                    slotPower[gi] <= !cardOk
                        || slotSt_q[gi] == dbm_pkg::SLOT_RAMP
                        || slotSt_q[gi] == dbm_pkg::SLOT_ON;
                    slotRamp[gi] <= cardOk
                        && slotSt_q[gi] == dbm_pkg::SLOT_RAMP;
                end
            end
            // R5 R6 R7 R8 id and spin-up lines
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    slotScsiId[gi*4 +: 4] <= 4'h0;
                    spinDelay[gi] <= 1'b0;
                end else begin
                    slotScsiId[gi*4 +: 4] <= (primary || !three
                        ? dbm_pkg::ID_BASE_PRI : dbm_pkg::ID_BASE_SEC)
                        + 4'(gi);
                    spinDelay[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // fault state, self-test flash, activity
    logic [NS-1:0] faultSet_q;
    logic [31:0] flashCnt_q, blinkCnt_q;
    logic flashing_q, flashDone_q, blink_q;
    // R9 R18 fault from either command path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            faultSet_q <= '0;
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (mgmtFaultValid && mgmtFaultSlot == 3'(s)) begin
                    faultSet_q[s] <= mgmtFaultOn;
                end
                if (esValid && esCmd.slot == 3'(s)) begin
                    if (esCmd.op == dbm_pkg::OP_FAULT_SET) begin
                        faultSet_q[s] <= 1'b1;
                    end else if (esCmd.op == dbm_pkg::OP_FAULT_CLR) begin
                        faultSet_q[s] <= 1'b0;
                    end
                end
            end
        end
    end
    // R10 one flash window per reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flashing_q <= 1'b0;
            flashDone_q <= 1'b0;
            flashCnt_q <= '0;
            blinkCnt_q <= '0;
            blink_q <= 1'b0;
        end else begin
            if (postPass && !flashDone_q && !flashing_q) begin
                flashing_q <= 1'b1;
                flashCnt_q <= '0;
            end else if (flashing_q) begin
                flashCnt_q <= flashCnt_q + 32'd1;
                if (flashCnt_q == 32'(FLASH_CYCLES - 1)) begin
                    flashing_q <= 1'b0;
                    flashDone_q <= 1'b1;
                end
            end
            blinkCnt_q <= blinkCnt_q + 32'd1;
            if (blinkCnt_q == 32'(BLINK_CYCLES - 1)) begin
                blinkCnt_q <= '0;
                blink_q <= !blink_q;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            faultLed <= '0;
            activityLed <= '0;
        end else begin
            faultLed <= flashing_q ? {NS{blink_q}} : faultSet_q;
            // R11 activity follows access
            activityLed <= act_q;
        end
    end

    // fan speed per window, single low report
    logic [31:0] winCnt_q;
    logic [15:0] tachCnt_q [dbm_pkg::NFAN];
    logic [15:0] fanSpeed_q [dbm_pkg::NFAN];
    logic fanFailSeen_q;
    // R12 pulse counting per fan
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            winCnt_q <= '0;
            fanFailSeen_q <= 1'b0;
            fanLowMsg <= 1'b0;
            fanLowIdx <= 1'b0;
            for (int f = 0; f < dbm_pkg::NFAN; f++) begin
                tachCnt_q[f] <= '0;
                fanSpeed_q[f] <= '0;
            end
        end else begin
            fanLowMsg <= 1'b0;
            winCnt_q <= winCnt_q + 32'd1;
            for (int f = 0; f < dbm_pkg::NFAN; f++) begin
                if (tach_q[f] && !tachOld_q[f]
                        && tachCnt_q[f] != 16'hFFFF) begin
                    tachCnt_q[f] <= tachCnt_q[f] + 16'd1;
                end
            end
            if (winCnt_q == 32'(FAN_WIN_CYCLES - 1)) begin
                winCnt_q <= '0;
                for (int f = dbm_pkg::NFAN - 1; f >= 0; f--) begin
                    fanSpeed_q[f] <= tachCnt_q[f];
                    tachCnt_q[f] <= '0;
                    // R13 R14 R19 first low fan only
                    if (tachCnt_q[f] < FAN_LOW_THRESH && !fanFailSeen_q) begin
                        fanFailSeen_q <= 1'b1;
                        fanLowMsg <= 1'b1;
                        fanLowIdx <= 1'(f);
                    end
                end
            end
        end
    end

    // R16 program store, boot part write-protected
    logic [7:0] progMem [dbm_pkg::PROG_BYTES];
    always_ff @(posedge clk) begin
        if (progWrEn && progAddr >= dbm_pkg::BOOT_END) begin
            progMem[progAddr] <= progWrData;
        end
        progRdData <= progMem[progAddr];
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            progWrRefused <= 1'b0;
        end else begin
            progWrRefused <= progWrEn && progAddr < dbm_pkg::BOOT_END;
        end
    end

    // R17 private bus: ptr write, restart, one byte
    logic [5:0] sym_q, idx;
    logic [1:0] qtr_q;
    logic [15:0] div_q;
    logic [35:0] tx_q;
    logic [7:0] rx_q;
    logic tick, isStart, isStop, sclLow, sdaLow;
    logic i2cStart;
    logic [6:0] devAddr;
    logic [7:0] devPtr;
    assign i2cStart = esValid && !i2cBusy_q
        && (esCmd.op == dbm_pkg::OP_READ_TEMP
        || esCmd.op == dbm_pkg::OP_READ_STORE);
    assign devAddr = esCmd.op == dbm_pkg::OP_READ_TEMP
        ? dbm_pkg::TEMP_ADDR : dbm_pkg::STORE_ADDR;
    assign devPtr = esCmd.op == dbm_pkg::OP_READ_TEMP
        ? dbm_pkg::TEMP_PTR : esCmd.arg;
    assign isStart = sym_q == 6'h00 || sym_q == dbm_pkg::SYM_RSTART;
    assign isStop = sym_q == dbm_pkg::SYM_STOP;
    assign idx = sym_q < dbm_pkg::SYM_RSTART ? sym_q - 6'h01
        : sym_q - 6'h02;
    // slave stretching holds the high quarter
    assign tick = div_q == dbm_pkg::I2C_QDIV && !(qtr_q == 2'd2 && !scl_q);
    always_comb begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        if (i2cBusy_q) begin
            if (isStop) begin
                sclLow = qtr_q == 2'd0;
                sdaLow = qtr_q < 2'd2;
            end else if (isStart) begin
                sclLow = qtr_q == 2'd0 || qtr_q == 2'd3;
                sdaLow = qtr_q >= 2'd2;
            end else begin
                sclLow = qtr_q == 2'd0 || qtr_q == 2'd3;
                sdaLow = !tx_q[6'd35 - idx];
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            i2cBusy_q <= 1'b0;
            i2cDone_q <= 1'b0;
            sym_q <= '0;
            qtr_q <= '0;
            div_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
        end else begin
            i2cDone_q <= 1'b0;
            if (i2cStart) begin
                i2cBusy_q <= 1'b1;
                sym_q <= '0;
                qtr_q <= '0;
                div_q <= '0;
                tx_q <= {devAddr, 2'b01, devPtr, 1'b1, devAddr, 2'b11,
                    8'hFF, 1'b1};
            end else if (i2cBusy_q) begin
                div_q <= tick ? 16'h0000
                    : (div_q == dbm_pkg::I2C_QDIV ? div_q : div_q + 16'd1);
                if (tick) begin
                    qtr_q <= qtr_q + 2'd1;
                    if (qtr_q == 2'd2 && !isStart && !isStop
                            && idx >= dbm_pkg::RX_FIRST
                            && idx <= dbm_pkg::RX_LAST) begin
                        rx_q <= {rx_q[6:0], sda_q};
                    end
                    if (qtr_q == 2'd3) begin
                        sym_q <= sym_q + 6'h01;
                        if (isStop) begin
                            i2cBusy_q <= 1'b0;
                            i2cDone_q <= 1'b1;
                        end
                    end
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            privSclOe <= 1'b0;
            privSdaOe <= 1'b0;
            privSclOut <= 1'b0;
            privSdaOut <= 1'b0;
        end else begin
            privSclOe <= sclLow;
            privSdaOe <= sdaLow;
            privSclOut <= 1'b0;
            privSdaOut <= 1'b0;
        end
    end

    // R15 R18 answers to enclosure services
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            esRsp <= '0;
        end else begin
            esRsp <= '0;
            if (i2cDone_q) begin
                esRsp.valid <= 1'b1;
                esRsp.data <= {8'h00, rx_q};
            end else if (esValid) begin
                esRsp.valid <= 1'b1;
                if (esCmd.op == dbm_pkg::OP_FAN_STAT) begin
                    esRsp.data <= fanSpeed_q[esCmd.arg[0]];
                end else if (esCmd.op == dbm_pkg::OP_READ_TEMP
                        || esCmd.op == dbm_pkg::OP_READ_STORE) begin
                    esRsp.valid <= i2cBusy_q;
                    esRsp.err <= i2cBusy_q;
                end else if (esCmd.op > dbm_pkg::OP_READ_STORE
                        || esCmd.slot >= 3'(NS)) begin
                    esRsp.err <= 1'b1;
                end
            end
        end
    end
endmodule : dbm_bay_manager
`default_nettype wire

// [test/dbm_host_model.sv]
/* dbm_host_model: host sending enclosure services commands.
   Assumes the bench raises go for one cycle per command. */
`timescale 1ns/10ps
`default_nettype none
module dbm_host_model (
    // clock
    input wire logic clk,
    // bench request
    input wire logic go,
    input wire dbm_pkg::dbm_cmd_t req,
    // to the target
    output dbm_pkg::dbm_cmd_t esCmd
);
    always_ff @(posedge clk) begin
        esCmd <= go ? req : '0;
    end
endmodule : dbm_host_model
`default_nettype wire

// [test/dbm_bay_manager_sva.sv]
/* dbm_bay_manager_sva: port checks, bound below.
   Assumes straps held while checked. */
`timescale 1ns/10ps
`default_nettype none
module dbm_bay_manager_sva #(
    parameter int SETTLE_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // inputs
    input wire logic cardPresent,
    input wire logic primaryStrap,
    input wire logic threeSlotBoard,
    input wire logic sysPowerOn,
    input wire logic [4:0] drvPresent,
    input wire logic [4:0] drvActive,
    input wire dbm_pkg::dbm_cmd_t esCmd,
    // outputs
    input wire dbm_pkg::dbm_rsp_t esRsp,
    input wire logic fanLowMsg,
    input wire logic [4:0] slotPower,
    input wire logic [4:0] slotRamp,
    input wire logic [4:0] activityLed,
    input wire logic [19:0] slotScsiId
);
    logic [3:0] up_q;
    wire logic run;
    // sync chains stale after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    end
    assign run = (up_q > 4'h8);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_nocard_power: assert property ((run && !cardPresent)[*5]
        |-> slotPower == 5'h1F) else $error("no card power");
    a_powerdown_off: assert property (run && cardPresent && esCmd.valid
        && esCmd.op == 3'h2 && esCmd.slot == 3'h2 |-> ##2 !slotPower[2])
        else $error("failed slot powered");
    a_settle_wait: assert property (run && cardPresent
        && $rose(slotPower[2]) |-> $past(drvPresent[2], SETTLE_CYCLES))
        else $error("early power");
    a_ramp_power: assert property ((slotRamp & ~slotPower) == 5'h00)
        else $error("ramp unpowered");
    a_withdraw_off: assert property (run && sysPowerOn && cardPresent
        && $fell(drvPresent[4]) |-> ##[1:5] !slotPower[4])
        else $error("withdrawn slot powered");
    a_id_primary: assert property ((run && primaryStrap)[*4]
        |-> slotScsiId == 20'h4_3210) else $error("primary ids");
    a_id_second: assert property ((run && threeSlotBoard && !primaryStrap)[*4]
        |-> slotScsiId[11:0] == 12'hA98) else $error("secondary ids");
    a_activity_led: assert property ((run && $stable(drvActive))[*5]
        |-> activityLed == drvActive) else $error("activity led");
    a_cmd_answer: assert property (esCmd.valid && esCmd.op < 3'h4
        && esCmd.slot < 3'h5 |=> esRsp.valid && !esRsp.err)
        else $error("no answer");
    a_bad_err: assert property (esCmd.valid && (esCmd.op > 3'h5
        || esCmd.slot > 3'h4) |=> esRsp.valid && esRsp.err)
        else $error("bad command taken");
    a_fan_once: assert property (fanLowMsg |=> !fanLowMsg[*8])
        else $error("fan repeat");
    c_ramp: cover property ($rose(slotRamp[2]));
    c_fan: cover property (fanLowMsg);
    c_err: cover property (esRsp.valid && esRsp.err);
endmodule : dbm_bay_manager_sva
bind dbm_bay_manager dbm_bay_manager_sva #(.SETTLE_CYCLES(SETTLE_CYCLES))
    u_dbm_bay_manager_sva (.*);
`default_nettype wire

// [test/dbm_bay_manager_test.sv]
/* dbm_bay_manager_test: self-checking bench for dbm_bay_manager.
   Assumes shortened counts and a pulled-up private bus. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errTotal++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module dbm_bay_manager_test;
    logic clk = 1'b0, rst_b = 1'b0, cardPresent = 1'b1, primaryStrap = 1'b1;
    logic threeSlotBoard = 1'b0, sysPowerOn = 1'b0, postPass = 1'b0;
    logic mgmtFaultValid = 1'b0, mgmtFaultOn = 1'b0, go = 1'b0, expErr;
    logic [2:0] mgmtFaultSlot = 3'h0;
    logic [4:0] drvPresent = 5'h00, drvActive = 5'h00, a;
    logic [1:0] fanTach = 2'h0;
    logic fanLowMsg, fanLowIdx, privSclOut, privSclOe, privSdaOut, privSdaOe;
    logic progWrEn = 1'b0, progWrRefused;
    logic [14:0] progAddr = 15'h0000;
    logic [7:0] progWrData = 8'h00, progRdData;
    logic [4:0] slotPower, slotRamp, faultLed, activityLed, spinDelay;
    logic [19:0] slotScsiId;
    dbm_pkg::dbm_cmd_t req = '0, esCmd;
    dbm_pkg::dbm_rsp_t esRsp;
    logic expQ[$];
    logic [31:0] seed = 32'h0001_641A;
    int errTotal = 0, nTests = 0, fanMsgs = 0, cycles = 0, i;
    // released lines float high
    wire logic privSclIn = !privSclOe;
    wire logic privSdaIn = !privSdaOe;
    always #5 clk = ~clk;
    dbm_bay_manager #(.SETTLE_CYCLES(20), .RAMP_CYCLES(10), .FLASH_CYCLES(64),
        .BLINK_CYCLES(8), .FAN_WIN_CYCLES(100))
    u_dbm_bay_manager (.*);
    dbm_host_model u_dbm_host_model (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic completeRun();
        if (errTotal == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : completeRun
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic cmd(input logic [2:0] op, input logic [2:0] sl,
            input logic e, input logic ex);
        @(posedge clk);
        go <= 1'b1;
        req <= {1'b1, op, sl, 8'h00};
        if (ex) expQ.push_back(e);
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : cmd
    // fan 0 stopped, fan 1 random
    always @(posedge clk) begin
        seed <= xs(seed);
        fanTach <= {seed[0], 1'b0};
        cycles++;
        if (cycles == 45000) begin
            errTotal++;
            completeRun();
        end
    end
    always @(negedge clk) begin
        if (esRsp.valid === 1'b1) begin
            expErr = expQ.pop_front();
            `CHK("esRsp.err", expErr, esRsp.err)
        end
        if (fanLowMsg === 1'b1) begin
            fanMsgs++;
            `CHK("fanLowIdx", 1'b0, fanLowIdx)
        end
    end
    initial begin
        @(negedge clk) `CHK("slotPower", 5'h1F, slotPower)
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cyc(8);
        `CHK("slotScsiId", 20'h4_3210, slotScsiId)
        `CHK("spinDelay", 5'h1F, spinDelay)
        @(posedge clk) progWrEn <= 1'b1;
        progAddr <= 15'h2005;
        progWrData <= seed[7:0];
        @(posedge clk) progAddr <= 15'h0005;
        @(posedge clk) progWrEn <= 1'b0;
        progAddr <= 15'h2005;
        @(negedge clk) `CHK("progWrRefused", 1'b1, progWrRefused)
        cyc(1);
        `CHK("progRdData", progWrData, progRdData)
        @(posedge clk) postPass <= 1'b1;
        cyc(4);
        a = faultLed;
        cyc(8);
        `CHK("faultLed", ~a, faultLed)
        cyc(70);
        `CHK("faultLed", 5'h00, faultLed)
        @(posedge clk) mgmtFaultValid <= 1'b1;
        mgmtFaultSlot <= 3'h3;
        mgmtFaultOn <= 1'b1;
        @(posedge clk) mgmtFaultValid <= 1'b0;
        cyc(3);
        `CHK("faultLed", 5'h08, faultLed)
        cmd(3'h0, 3'h1, 1'b0, 1'b1);
        cyc(2);
        `CHK("faultLed", 5'h0A, faultLed)
        cmd(3'h1, 3'h3, 1'b0, 1'b1);
        cyc(2);
        `CHK("faultLed", 5'h02, faultLed)
        for (i = 0; i < 4; i++) begin
            @(posedge clk) drvActive <= seed[4:0];
            cyc(6);
            `CHK("activityLed", drvActive, activityLed)
        end
        @(posedge clk) sysPowerOn <= 1'b1;
        drvPresent <= 5'h04;
        cyc(10);
        `CHK("slotPower", 5'h00, slotPower)
        cyc(25);
        `CHK("slotPower", 5'h04, slotPower)
        cmd(3'h2, 3'h2, 1'b0, 1'b1);
        cyc(0);
        `CHK("slotPower", 5'h00, slotPower)
        @(posedge clk) drvPresent <= 5'h10;
        cyc(40);
        `CHK("slotPower", 5'h10, slotPower)
        @(posedge clk) drvPresent <= 5'h00;
        cyc(5);
        `CHK("slotPower", 5'h00, slotPower)
        for (i = 0; i < 4; i++) cmd(i[2:0], 3'h4, 1'b0, 1'b1);
        cmd(3'h6, 3'h0, 1'b1, 1'b1);
        cmd(3'h7, 3'h0, 1'b1, 1'b1);
        cmd(3'h0, 3'h5, 1'b1, 1'b1);
        cmd(3'h4, 3'h0, 1'b0, 1'b0);
        cmd(3'h5, 3'h0, 1'b1, 1'b1);
        expQ.push_back(1'b0);
        for (i = 0; i < 40000 && expQ.size() > 0; i++) @(posedge clk);
        cyc(2);
        `CHK("readDone", 1'b1, expQ.size() == 0)
        @(posedge clk) primaryStrap <= 1'b0;
        threeSlotBoard <= 1'b1;
        cyc(6);
        `CHK("slotScsiId", 12'hA98, slotScsiId[11:0])
        @(posedge clk) cardPresent <= 1'b0;
        cyc(6);
        `CHK("slotPower", 5'h1F, slotPower)
        `CHK("fanMsgs", 1, fanMsgs)
        completeRun();
    end
endmodule : dbm_bay_manager_test
`default_nettype wire
